// ==== inc/phy_mii_pkg.sv ====
// Constants for the MII pin logic of a 100/10 Mb/s transceiver.
// Assumes a 200 MHz system clock; register offsets are 5-bit.
package phy_mii_pkg;
  // ==========================================
  // Register offsets
  localparam logic [4:0] ADDR_ISR = 5'h11;
  localparam logic [4:0] ADDR_IMR = 5'h12;
  localparam logic [4:0] ADDR_BYP = 5'h18;
  localparam logic [4:0] ADDR_SSR = 5'h19;
  localparam logic [4:0] ADDR_TEN = 5'h1b;
  // ==========================================
  // Field positions
  localparam int BIT_CODER  = 14;
  localparam int BIT_ALIGN  = 12;
  localparam int BIT_SERIAL = 9;
  localparam int SSR_DRV    = 8;
  localparam int SSR_TCM    = 9;
  localparam int ISR_COL    = 0;
  localparam int ISR_FC     = 1;
  localparam int ISR_RXER   = 2;
  localparam int ISR_SPD    = 3;
  localparam int ISR_DPX    = 4;
  // ==========================================
  // Reset values and codes
  localparam logic [15:0] IMR_RST  = 16'h001f;
  localparam logic [3:0]  FC_NIB   = 4'he;
  localparam logic [1:0]  OP_READ  = 2'h2;
  localparam logic [1:0]  OP_WRITE = 2'h1;
  localparam int          PRE_LEN  = 32;
  // ==========================================
  // Timing, rates in kHz
  localparam int SYS_KHZ      = 200000;
  localparam int RATE_100_KHZ = 25000;
  localparam int RATE_10_KHZ  = 2500;
  localparam int RATE_SER_KHZ = 10000;
  localparam int MDC_MAX_KHZ  = 16670;
  localparam int HALF_100 = SYS_KHZ / (2 * RATE_100_KHZ);
  localparam int HALF_10  = SYS_KHZ / (2 * RATE_10_KHZ);
  localparam int HALF_SER = SYS_KHZ / (2 * RATE_SER_KHZ);
  localparam int MDC_MIN  = SYS_KHZ / (2 * MDC_MAX_KHZ);
  // ==========================================
  // Management frame states
  typedef enum logic [2:0] {
    MD_PRE, MD_HDR, MD_TA, MD_DATA
  } mdio_state_t;
endpackage

// ==== src/phy_mii_pins.sv ====
// MII pin logic: receive/transmit signalling, straps, management port.
// Assumes core-side inputs on sys_clk_i; pins arrive asynchronously.
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
module phy_mii_pins (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  // Software register port
  input  wire logic [4:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  // Core receive side
  input  wire logic [4:0]  rx_data_i,
  input  wire logic        rx_valid_i,
  input  wire logic        rx_error_i,
  input  wire logic        rx_false_carrier_i,
  input  wire logic        carrier_i,
  input  wire logic        collision_i,
  input  wire logic        sqe_i,
  input  wire logic        speed_100_i,
  input  wire logic        full_duplex_i,
  // Core transmit side
  output logic      [4:0]  tx_code_o,
  output logic             tx_valid_o,
  output logic             tx_halt_o,
  output logic             tx_strobe_o,
  // Straps and status
  input  wire logic        tx_clock_source_strap_i,
  input  wire logic        serial_mode_strap_i,
  input  wire logic        coder_bypass_strap_i,
  input  wire logic        align_bypass_strap_i,
  output logic             drive_strength_o,
  output logic             ref_clock_out_o,
  // MII receive pins
  input  wire logic        rx_en_i,
  input  wire logic [3:0]  rxd_i,
  output logic      [3:0]  rxd_o,
  output logic             rxd_oe_n_o,
  input  wire logic        rx_dv_i,
  output logic             rx_dv_o,
  input  wire logic        rx_er_i,
  output logic             rx_er_o,
  output logic             rx_clk_o,
  input  wire logic        col_i,
  output logic             col_o,
  input  wire logic        crs_i,
  output logic             crs_o,
  output logic             col_crs_oe_n_o,
  // MII transmit pins
  input  wire logic        tx_clk_i,
  output logic             tx_clk_o,
  output logic             tx_clk_oe_n_o,
  input  wire logic [3:0]  txd_i,
  input  wire logic        tx_er_i,
  input  wire logic        tx_en_i,
  // Management pins
  input  wire logic        mdc_i,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe_n_o,
  output logic             mgmt_interrupt_n_o,
  output logic             mgmt_interrupt_n_oe_n_o
);
  // ==========================================
  // Synchronisers
  logic [13:0] s1;
  logic [13:0] s2;
  logic        txc_d;
  logic        mdc_d;
  logic [13:0] pins;
  assign pins = {mdio_i, mdc_i, tx_clk_i, tx_en_i, tx_er_i, txd_i,
                 rx_en_i, rx_dv_i, rx_er_i, crs_i, col_i};
  // Two stages for every pin; mdc is just another async pin
  always_ff @(posedge sys_clk_i)
  begin
    s1    <= pins;
    s2    <= s1;
    txc_d <= s2[11];
    mdc_d <= s2[12];
  end
  logic       col_s, crs_s, rxer_s, rxdv_s, rxen_s, txen_s, txer_s;
  logic       mdio_s, tx_rise, mdc_rise;
  logic [3:0] txd_s;
  assign {col_s, crs_s, rxer_s, rxdv_s, rxen_s} =
         {s2[0], s2[1], s2[2], s2[3], s2[4]};
  assign txd_s    = s2[8:5];
  assign txer_s   = s2[9];
  assign txen_s   = s2[10];
  assign mdio_s   = s2[13];
  assign tx_rise  = s2[11] & ~txc_d;
  assign mdc_rise = s2[12] & ~mdc_d;

  // ==========================================
  // Strap capture in the first cycle after reset release
  logic [3:0] rxd_s1, rxd_s2;
  logic [3:0] strap_s1, strap_s2;
  logic [4:0] strap_pins;
  logic       strap_done;
  logic [4:0] phy_addr_strap;
  logic       tx_clock_source_strap;
  // All four receive data pins and the strap pins, two stages each
  always_ff @(posedge sys_clk_i)
  begin
    rxd_s1   <= rxd_i;
    rxd_s2   <= rxd_s1;
    strap_s1 <= {align_bypass_strap_i, coder_bypass_strap_i,
                 serial_mode_strap_i, tx_clock_source_strap_i};
    strap_s2 <= strap_s1;
  end
  // Address bits 0..4: collision, rxd1, carrier, rxd3, receive error
  assign strap_pins = {rxer_s, rxd_s2[3], crs_s, rxd_s2[1], col_s};
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      strap_done       <= 1'b0;
      phy_addr_strap   <= 5'h00;
      drive_strength_o <= 1'b0;
      tx_clock_source_strap              <= 1'b0;
    end
    else if (!strap_done)
    begin
      strap_done       <= 1'b1;
      phy_addr_strap   <= strap_pins;
      drive_strength_o <= rxdv_s;
      tx_clock_source_strap              <= strap_s2[0];
    end
  end

  // ==========================================
  // Registers
  logic [15:0] interrupt_status_reg, imr;
  logic        coder_bypass_mode, align_bypass_mode, serial_mode;
  logic        md_wr;
  logic [4:0]  md_addr;
  logic [15:0] md_wdata;
  logic        md_isr_rd;
  logic        bypass, ser_eff;
  assign bypass  = coder_bypass_mode | align_bypass_mode;
  assign ser_eff = serial_mode & ~speed_100_i;
  // Writable mode bits; straps load them once, software after
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      imr               <= phy_mii_pkg::IMR_RST;
      coder_bypass_mode <= 1'b0;
      align_bypass_mode <= 1'b0;
      serial_mode       <= 1'b0;
    end
    else if (!strap_done)
    begin
      coder_bypass_mode <= strap_s2[2];
      align_bypass_mode <= strap_s2[3];
      serial_mode       <= strap_s2[1];
    end
    else if (reg_wr_i || md_wr)
    begin
      case (reg_wr_i ? reg_addr_i : md_addr)
        phy_mii_pkg::ADDR_IMR: imr <= reg_wr_i ? reg_wdata_i : md_wdata;
        phy_mii_pkg::ADDR_BYP:
        begin
          coder_bypass_mode <= reg_wr_i ?
            reg_wdata_i[phy_mii_pkg::BIT_CODER] :
            md_wdata[phy_mii_pkg::BIT_CODER];
          align_bypass_mode <= reg_wr_i ?
            reg_wdata_i[phy_mii_pkg::BIT_ALIGN] :
            md_wdata[phy_mii_pkg::BIT_ALIGN];
        end
        phy_mii_pkg::ADDR_TEN:
          serial_mode <= reg_wr_i ?
            reg_wdata_i[phy_mii_pkg::BIT_SERIAL] :
            md_wdata[phy_mii_pkg::BIT_SERIAL];
        default: imr <= imr;
      endcase
    end
  end
  // Read multiplexer shared by both access paths
  function automatic logic [15:0] reg_read(input logic [4:0] a);
    logic [15:0] v;
    v = 16'h0000;
    case (a)
      phy_mii_pkg::ADDR_ISR: v = interrupt_status_reg;
      phy_mii_pkg::ADDR_IMR: v = imr;
      phy_mii_pkg::ADDR_BYP:
      begin
        v[phy_mii_pkg::BIT_CODER] = coder_bypass_mode;
        v[phy_mii_pkg::BIT_ALIGN] = align_bypass_mode;
      end
      phy_mii_pkg::ADDR_SSR:
      begin
        v[4:0]                 = phy_addr_strap;
        v[phy_mii_pkg::SSR_DRV] = drive_strength_o;
        v[phy_mii_pkg::SSR_TCM] = tx_clock_source_strap;
      end
      phy_mii_pkg::ADDR_TEN: v[phy_mii_pkg::BIT_SERIAL] = serial_mode;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction
  // Read data stands one cycle after the strobe
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
      reg_rdata_o <= 16'h0000;
    else
      reg_rdata_o <= reg_rd_i ? reg_read(reg_addr_i) : 16'h0000;
  end

  // ==========================================
  // Interrupt status, sticky; set wins over read-clear
  logic [4:0] ev;
  logic       col_q, fc_q, er_q, spd_q, dpx_q, isr_clr;
  // Previous levels, tracked in reset too so no false change follows it
  always_ff @(posedge sys_clk_i)
  begin
    {col_q, fc_q, er_q, spd_q, dpx_q} <= {collision_i,
      rx_false_carrier_i, rx_error_i, speed_100_i, full_duplex_i};
  end
  assign ev[phy_mii_pkg::ISR_COL]  = collision_i & ~col_q;
  assign ev[phy_mii_pkg::ISR_FC]   = rx_false_carrier_i & ~fc_q;
  assign ev[phy_mii_pkg::ISR_RXER] = rx_error_i & ~er_q;
  assign ev[phy_mii_pkg::ISR_SPD]  = speed_100_i ^ spd_q;
  assign ev[phy_mii_pkg::ISR_DPX]  = full_duplex_i ^ dpx_q;
  assign isr_clr = md_isr_rd |
                   (reg_rd_i && reg_addr_i == phy_mii_pkg::ADDR_ISR);
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
      interrupt_status_reg <= 16'h0000;
    else
      interrupt_status_reg <= (isr_clr ? 16'h0000 : interrupt_status_reg) | {11'h000, ev};
  end
  // Open drain: pull low while any unmasked status is set
  assign mgmt_interrupt_n_o      = 1'b0;
  assign mgmt_interrupt_n_oe_n_o = ~|(interrupt_status_reg & imr);

  // ==========================================
  // Receive clock divider and output registers
  logic [6:0] rx_cnt, half;
  logic       rx_fall;
  assign half = speed_100_i ? 7'(phy_mii_pkg::HALF_100) :
                ser_eff     ? 7'(phy_mii_pkg::HALF_SER) :
                              7'(phy_mii_pkg::HALF_10);
  assign rx_fall = (rx_cnt >= half - 7'd1) && rx_clk_o;
  // Free-running clock, toggles every half period
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      rx_cnt   <= 7'd0;
      rx_clk_o <= 1'b0;
    end
    else if (rx_cnt >= half - 7'd1)
    begin
      rx_cnt   <= 7'd0;
      rx_clk_o <= ~rx_clk_o;
    end
    else
      rx_cnt <= rx_cnt + 7'd1;
  end
  // Outputs change on the falling edge, MAC samples on rising
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      rxd_o   <= 4'h0;
      rx_dv_o <= 1'b0;
      rx_er_o <= 1'b0;
    end
    else if (rx_fall)
    begin
      if (ser_eff)
      begin
        rxd_o   <= {3'h0, rx_data_i[0]};
        rx_dv_o <= rx_valid_i;
        rx_er_o <= 1'b0;
      end
      else if (align_bypass_mode)
      begin
        rxd_o   <= rx_data_i[3:0];
        rx_er_o <= rx_data_i[4];
        rx_dv_o <= rx_valid_i;
      end
      else if (coder_bypass_mode)
      begin
        rxd_o   <= rx_valid_i ? rx_data_i[3:0] : 4'h0;
        rx_er_o <= rx_valid_i & rx_data_i[4];
        rx_dv_o <= rx_valid_i;
      end
      else if (rx_valid_i)
      begin
        rxd_o   <= rx_data_i[3:0];
        rx_er_o <= rx_error_i;
        rx_dv_o <= 1'b1;
      end
      else
      begin
        rxd_o   <= rx_false_carrier_i ? phy_mii_pkg::FC_NIB : 4'h0;
        rx_er_o <= rx_false_carrier_i;
        rx_dv_o <= 1'b0;
      end
    end
  end
  // Collision and carrier follow the core every cycle
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      col_o <= 1'b0;
      crs_o <= 1'b0;
    end
    else
    begin
      col_o <= (collision_i & ~full_duplex_i) |
               (sqe_i & ~speed_100_i);
      crs_o <= carrier_i;
    end
  end
  // Pins stay released while straps are read
  assign rxd_oe_n_o     = ~(rxen_s & strap_done);
  assign col_crs_oe_n_o = ~strap_done;

  // ==========================================
  // Transmit clock source and sampling
  logic [2:0] ref_cnt;
  logic       ref_rise, tx_edge;
  assign ref_rise = (ref_cnt == 3'(phy_mii_pkg::HALF_100 - 1)) &&
                    !ref_clock_out_o;
  // Reference clock output, 25 MHz
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      ref_cnt         <= 3'd0;
      ref_clock_out_o <= 1'b0;
    end
    else if (ref_cnt == 3'(phy_mii_pkg::HALF_100 - 1))
    begin
      ref_cnt         <= 3'd0;
      ref_clock_out_o <= ~ref_clock_out_o;
    end
    else
      ref_cnt <= ref_cnt + 3'd1;
  end
  assign tx_clk_o      = ref_clock_out_o;
  assign tx_clk_oe_n_o = ~(tx_clock_source_strap & strap_done);
  assign tx_edge       = tx_clock_source_strap ? ref_rise : tx_rise;
  // Nibble or code-group taken on each rising transmit clock edge
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      tx_code_o   <= 5'h00;
      tx_valid_o  <= 1'b0;
      tx_halt_o   <= 1'b0;
      tx_strobe_o <= 1'b0;
    end
    else
    begin
      tx_strobe_o <= tx_edge;
      if (tx_edge)
      begin
        tx_valid_o <= txen_s;
        tx_halt_o  <= 1'b0;
        if (bypass)
          tx_code_o <= {txer_s, txd_s};
        else if (ser_eff)
          tx_code_o <= {4'h0, txd_s[0]};
        else if (speed_100_i && txen_s && txer_s)
        begin
          tx_code_o <= 5'h00;
          tx_halt_o <= 1'b1;
        end
        else
          tx_code_o <= {1'b0, txd_s};
      end
    end
  end

  // ==========================================
  // Management frame slave
  phy_mii_pkg::mdio_state_t md_st;
  logic [5:0]  md_cnt;
  logic [11:0] hdr;
  logic [12:0] full;
  logic [15:0] md_sh;
  logic        md_rd_hit, md_wr_hit;
  assign full = {hdr, mdio_s};
  // Frames sampled on management clock rising edges
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      md_st       <= phy_mii_pkg::MD_PRE;
      md_cnt      <= 6'd0;
      hdr         <= 12'h000;
      md_sh       <= 16'h0000;
      md_rd_hit   <= 1'b0;
      md_wr_hit   <= 1'b0;
      md_wr       <= 1'b0;
      md_addr     <= 5'h00;
      md_wdata    <= 16'h0000;
      md_isr_rd   <= 1'b0;
      mdio_o      <= 1'b1;
      mdio_oe_n_o <= 1'b1;
    end
    else
    begin
      md_wr     <= 1'b0;
      md_isr_rd <= 1'b0;
      if (mdc_rise)
      begin
        case (md_st)
          phy_mii_pkg::MD_PRE:
            if (mdio_s)
              md_cnt <= (md_cnt == 6'(phy_mii_pkg::PRE_LEN)) ?
                        md_cnt : md_cnt + 6'd1;
            else if (md_cnt == 6'(phy_mii_pkg::PRE_LEN))
            begin
              md_st  <= phy_mii_pkg::MD_HDR;
              md_cnt <= 6'd0;
            end
            else
              md_cnt <= 6'd0;
          phy_mii_pkg::MD_HDR:
          begin
            hdr    <= full[11:0];
            md_cnt <= md_cnt + 6'd1;
            if (md_cnt == 6'd12)
            begin
              md_st     <= phy_mii_pkg::MD_TA;
              md_cnt    <= 6'd0;
              md_addr   <= full[4:0];
              md_rd_hit <= full[12] && full[11:10] ==
                phy_mii_pkg::OP_READ && full[9:5] == phy_addr_strap;
              md_wr_hit <= full[12] && full[11:10] ==
                phy_mii_pkg::OP_WRITE && full[9:5] == phy_addr_strap;
              md_sh     <= reg_read(full[4:0]);
              md_isr_rd <= full[12] && full[11:10] ==
                phy_mii_pkg::OP_READ && full[9:5] == phy_addr_strap &&
                full[4:0] == phy_mii_pkg::ADDR_ISR;
            end
          end
          phy_mii_pkg::MD_TA:
          begin
            md_cnt <= md_cnt + 6'd1;
            if (md_cnt == 6'd0)
            begin
              mdio_o      <= 1'b0;
              mdio_oe_n_o <= ~md_rd_hit;
            end
            else
            begin
              mdio_o <= md_sh[15];
              md_sh  <= {md_sh[14:0], 1'b0};
              md_st  <= phy_mii_pkg::MD_DATA;
              md_cnt <= 6'd0;
            end
          end
          phy_mii_pkg::MD_DATA:
          begin
            md_cnt <= md_cnt + 6'd1;
            mdio_o <= md_sh[15];
            md_sh  <= {md_sh[14:0], mdio_s};
            if (md_cnt == 6'd15)
            begin
              mdio_oe_n_o <= 1'b1;
              mdio_o      <= 1'b1;
              md_wr       <= md_wr_hit;
              md_wdata    <= {md_sh[14:0], mdio_s};
              md_st       <= phy_mii_pkg::MD_PRE;
              md_cnt      <= 6'd0;
            end
          end
          default: md_st <= phy_mii_pkg::MD_PRE;
        endcase
      end
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_hold100;
    ($stable(rx_clk_o) && speed_100_i) [*3];
  endsequence
  a_rx_clk_rate: assert property ($rose(rx_clk_o) && speed_100_i
    ##1 s_hold100 |=> $fell(rx_clk_o))
    else $error("receive clock half period wrong");
  a_dv_only_valid: assert property (rx_fall && !rx_valid_i
    |=> !rx_dv_o)
    else $error("data valid without valid data");
  a_false_carrier: assert property (rx_fall && !bypass && !ser_eff
    && !rx_valid_i && rx_false_carrier_i
    |=> rxd_o == phy_mii_pkg::FC_NIB && rx_er_o && !rx_dv_o)
    else $error("false carrier not signalled");
  a_rxd4_bypass: assert property (rx_fall && align_bypass_mode
    && !ser_eff |=> rx_er_o == $past(rx_data_i[4]))
    else $error("bit 4 not on error pin");
  a_tx_halt: assert property (tx_edge && speed_100_i && !bypass
    && txen_s && txer_s |=> tx_halt_o && tx_strobe_o)
    else $error("halt not sent");
  a_tx_er_ignored: assert property (tx_edge && !speed_100_i
    && !bypass |=> !tx_halt_o && !tx_code_o[4])
    else $error("transmit error altered data");
  a_rx_tristate: assert property (!rx_en_i [*3] |-> rxd_oe_n_o)
    else $error("receive pins driven while disabled");
  a_irq_set: assert property (|(ev & imr[4:0])
    |=> !mgmt_interrupt_n_oe_n_o)
    else $error("interrupt not raised");
  a_irq_clear: assert property (reg_rd_i && !md_isr_rd && !(|ev)
    && reg_addr_i == phy_mii_pkg::ADDR_ISR
    |=> interrupt_status_reg == 16'h0000 && mgmt_interrupt_n_oe_n_o)
    else $error("status read did not clear");
  a_strap_addr: assert property (!strap_done |=> phy_addr_strap
    == $past(strap_pins))
    else $error("address strap wrong");
  a_col_half: assert property (collision_i && !full_duplex_i
    |=> col_o)
    else $error("collision not shown");
endmodule

// ==== test/mac_model.sv ====
// MAC model on the transmit pins: makes the transmit clock, drives data.
// Assumes the bench supplies the nibble, enable and error to send.
`timescale 1ns/1ps
module mac_model (
  // Values from the bench
  input  wire logic [3:0] nib_i,
  input  wire logic       en_i,
  input  wire logic       er_i,
  // MII transmit pins
  output logic            tx_clk_o = 1'b0,
  output logic      [3:0] txd_o = 4'h0,
  output logic            tx_en_o = 1'b0,
  output logic            tx_er_o = 1'b0
);
  // ==========================================
  // Free-running 64 ns transmit clock
  always #32 tx_clk_o = ~tx_clk_o;
  // Pins move on the falling edge, clear of the sampling edge
  always @(negedge tx_clk_o)
  begin
    txd_o   <= nib_i;
    tx_en_o <= en_i;
    tx_er_o <= er_i;
  end
endmodule

// ==== test/testbench.sv ====
// Bench for the MII pin logic: straps, registers, receive and transmit.
// Assumes the MAC model on the transmit pins; one management read is run.
`timescale 1ns/1ps
module testbench;
  // ==========================================
  // Signals
  logic sys_clk_i = 0, rstn_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic [4:0] reg_addr_i = 0, rx_data_i = 0, tx_code_o;
  logic [15:0] reg_wdata_i = 0, reg_rdata_o, rd_val;
  logic rx_valid_i = 0, rx_error_i = 0, rx_false_carrier_i = 0;
  logic carrier_i = 0, collision_i = 0, sqe_i = 0, speed_100_i = 1;
  logic full_duplex_i = 0, tx_clock_source_strap_i = 0;
  logic serial_mode_strap_i = 1, coder_bypass_strap_i = 0;
  logic align_bypass_strap_i = 0, rx_en_i = 1, rx_dv_i = 1, rx_er_i = 0;
  logic col_i = 1, crs_i = 1, mdc_i = 0, mdio_i = 1, en = 0, er = 0;
  logic [3:0] rxd_i = 4'h8, txd_i, rxd_o, nib = 0;
  logic tx_valid_o, tx_halt_o, tx_strobe_o, drive_strength_o, col_o;
  logic ref_clock_out_o, rxd_oe_n_o, rx_dv_o, rx_er_o, rx_clk_o, crs_o;
  logic col_crs_oe_n_o, tx_clk_i, tx_clk_o, tx_clk_oe_n_o, tx_er_i;
  logic tx_en_i, mdio_o, mdio_oe_n_o, mgmt_interrupt_n_o;
  logic mgmt_interrupt_n_oe_n_o;
  int num_errors = 0, total_checks = 0, cycles = 0;
  // ==========================================
  // Design and far side
  phy_mii_pins DUT (.sys_clk_i, .rstn_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .rx_data_i, .rx_valid_i,
    .rx_error_i, .rx_false_carrier_i, .carrier_i, .collision_i, .sqe_i,
    .speed_100_i, .full_duplex_i, .tx_code_o, .tx_valid_o, .tx_halt_o,
    .tx_strobe_o, .tx_clock_source_strap_i, .serial_mode_strap_i,
    .coder_bypass_strap_i, .align_bypass_strap_i, .drive_strength_o,
    .ref_clock_out_o, .rx_en_i, .rxd_i, .rxd_o, .rxd_oe_n_o, .rx_dv_i,
    .rx_dv_o, .rx_er_i, .rx_er_o, .rx_clk_o, .col_i, .col_o, .crs_i,
    .crs_o, .col_crs_oe_n_o, .tx_clk_i, .tx_clk_o, .tx_clk_oe_n_o,
    .txd_i, .tx_er_i, .tx_en_i, .mdc_i, .mdio_i, .mdio_o, .mdio_oe_n_o,
    .mgmt_interrupt_n_o, .mgmt_interrupt_n_oe_n_o);
  mac_model mac (.nib_i(nib), .en_i(en), .er_i(er), .tx_clk_o(tx_clk_i),
    .txd_o(txd_i), .tx_en_o(tx_en_i), .tx_er_o(tx_er_i));
  // 200 MHz clock and a ceiling on the run
  always #2.5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end
  // ==========================================
  // Shared tasks
  task automatic chk(input string what, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp)
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    if (seen !== exp)
      num_errors++;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 rd_val = reg_rdata_o;
  endtask
  // Two receive clock falls so the new inputs reach the pins
  task automatic rx_wait();
    repeat (2) @(negedge rx_clk_o);
    cyc(2);
  endtask
  // Three transmit edges so the MAC value is taken, then the strobe
  task automatic tx_send(input logic [3:0] n, input logic e);
    nib <= n;
    er <= e;
    en <= 1'b1;
    repeat (3) @(posedge tx_clk_i);
    @(posedge sys_clk_i iff tx_strobe_o === 1'b1);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic s_straps_regs();
    rd(phy_mii_pkg::ADDR_SSR);
    chk("phy addr", {11'h0, rd_val[4:0]}, 16'h000d);
    chk("drive", {14'h0, rd_val[8], drive_strength_o}, 16'h0003);
    chk("tx clk oe", {15'h0, rd_val[9] | ~tx_clk_oe_n_o}, 16'h0);
    rd(phy_mii_pkg::ADDR_TEN);
    chk("serial", {15'h0, rd_val[9]}, 16'h0001);
    wr(phy_mii_pkg::ADDR_SSR, 16'hffff);
    rd(phy_mii_pkg::ADDR_SSR);
    chk("addr kept", {11'h0, rd_val[4:0]}, 16'h000d);
    rd(5'h05);
    chk("unmapped", rd_val, 16'h0000);
  endtask
  task automatic s_tx();
    tx_send(4'ha, 1'b0);
    chk("tx nib", {10'h0, tx_valid_o, tx_code_o}, 16'h002a);
    tx_send(4'ha, 1'b1);
    chk("halt", {10'h0, tx_halt_o, tx_code_o}, 16'h0020);
    speed_100_i <= 1'b0;
    tx_send(4'h5, 1'b1);
    chk("serial tx", {10'h0, tx_halt_o, tx_code_o}, 16'h0001);
    wr(phy_mii_pkg::ADDR_TEN, 16'h0000);
    tx_send(4'h6, 1'b1);
    chk("10m nib", {11'h0, tx_halt_o, tx_code_o[3:0]}, 16'h0006);
    speed_100_i <= 1'b1;
    wr(phy_mii_pkg::ADDR_BYP, 16'h4000);
    tx_send(4'h3, 1'b1);
    chk("bypass tx", {11'h0, tx_code_o}, 16'h0013);
  endtask
  task automatic s_rx();
    rx_data_i <= 5'h15;
    rx_valid_i <= 1'b1;
    rx_wait();
    chk("bypass rx", {10'h0, rx_dv_o, rx_er_o, rxd_o}, 16'h0035);
    wr(phy_mii_pkg::ADDR_BYP, 16'h1000);
    rx_data_i <= 5'h1a;
    rx_valid_i <= 1'b0;
    rx_wait();
    chk("align rx", {10'h0, rx_dv_o, rx_er_o, rxd_o}, 16'h001a);
    wr(phy_mii_pkg::ADDR_BYP, 16'h0000);
    rx_valid_i <= 1'b1;
    rx_data_i <= 5'h09;
    rx_error_i <= 1'b1;
    rx_wait();
    chk("rx err", {10'h0, rx_dv_o, rx_er_o, rxd_o}, 16'h0039);
    rx_valid_i <= 1'b0;
    rx_error_i <= 1'b0;
    rx_false_carrier_i <= 1'b1;
    rx_wait();
    chk("false car", {10'h0, rx_dv_o, rx_er_o, rxd_o}, 16'h001e);
    rx_en_i <= 1'b0;
    cyc(4);
    chk("rx off", {15'h0, rxd_oe_n_o}, 16'h0001);
    rx_en_i <= 1'b1;
    cyc(4);
    chk("rx on", {15'h0, rxd_oe_n_o}, 16'h0000);
  endtask
  task automatic s_col_irq();
    collision_i <= 1'b1;
    carrier_i <= 1'b1;
    cyc(3);
    chk("col irq", {14'h0, col_o, mgmt_interrupt_n_oe_n_o}, 16'h0002);
    chk("crs", {13'h0, crs_o, col_crs_oe_n_o, mgmt_interrupt_n_o},
        16'h0004);
    rd(phy_mii_pkg::ADDR_ISR);
    chk("isr col", {15'h0, rd_val[phy_mii_pkg::ISR_COL]}, 16'h0001);
    cyc(2);
    chk("irq off", {15'h0, mgmt_interrupt_n_oe_n_o}, 16'h0001);
    full_duplex_i <= 1'b1;
    cyc(3);
    chk("col fdx", {15'h0, col_o}, 16'h0000);
    speed_100_i <= 1'b0;
    sqe_i <= 1'b1;
    cyc(3);
    chk("sqe", {15'h0, col_o}, 16'h0001);
  endtask
  // One management bit; 20 cycles a period keeps the clock at 10 MHz
  task automatic md_bit(input logic b, output logic seen);
    mdio_i <= b;
    cyc(10);
    seen = mdio_o;
    mdc_i <= 1'b1;
    cyc(10);
    mdc_i <= 1'b0;
  endtask
  // Management read of the self status word at the strapped address
  task automatic s_mdio();
    logic [13:0] hdr;
    logic [15:0] got;
    logic        bit_seen;
    hdr = {4'b0110, 5'h0d, phy_mii_pkg::ADDR_SSR};
    got = 16'h0000;
    repeat (32) md_bit(1'b1, bit_seen);
    for (int i = 13; i >= 0; i--)
      md_bit(hdr[i], bit_seen);
    md_bit(1'b1, bit_seen);
    chk("md turn", {14'h0, mdio_oe_n_o, mdio_o}, 16'h0000);
    md_bit(1'b1, bit_seen);
    for (int i = 15; i >= 0; i--)
    begin
      md_bit(1'b1, bit_seen);
      got[i] = bit_seen;
    end
    chk("md data", got, 16'h010d);
    cyc(10);
    chk("md free", {15'h0, mdio_oe_n_o}, 16'h0001);
  endtask
  task automatic s_reset2();
    coder_bypass_strap_i <= 1'b1;
    tx_clock_source_strap_i <= 1'b1;
    rstn_i <= 1'b0;
    cyc(6);
    rstn_i <= 1'b1;
    cyc(3);
    rd(phy_mii_pkg::ADDR_BYP);
    chk("coder strap", {15'h0, rd_val[14]}, 16'h0001);
    @(posedge tx_clk_o);
    cyc(3);
    chk("tx clk hi", {14'h0, tx_clk_oe_n_o, tx_clk_o}, 16'h0001);
    cyc(1);
    chk("tx clk lo", {15'h0, tx_clk_o}, 16'h0000);
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    cyc(6);
    rstn_i <= 1'b1;
    cyc(3);
    s_straps_regs();
    s_tx();
    s_rx();
    s_col_irq();
    s_mdio();
    s_reset2();
    tally_and_finish();
  end
endmodule
